// File: ccss_core.sv
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// - Machine cycle is 12 or 6 clocks
// - Reset starts in standard speed
// - Standard speed divides oscillator by two
// - Mode bit speeds CPU and all peripherals by default
// - Peripheral doubles only when its bit clear
// - Mode change applied on divided clock edge
// - Boot bit forces double speed after reset
// - Register at 8Fh with documented bit order
// - Doubled peripheral sees half timebase period
// - Peripheral bit selects 6 or 12 periods
// - Peripheral bits matter only in double mode
// - Control bits reset to zero
module ccss_core (
  // Clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       reset_n_in,
  // Nonvolatile boot option
  input  wire logic       boot_double_speed_in,
  // Register port
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  // Timebase strobes
  output logic            cpu_cycle_en_out,
  output logic      [5:0] periph_cycle_en_out,
  output logic            double_active_out
);
  ccss_pkg::ccss_state_s state_reg;
  ccss_pkg::ccss_state_s state_next;
  ccss_pkg::ccss_bus_s   bus;
  logic                  boot_seen_reg;

  assign bus.addr  = addr_in;
  assign bus.wdata = wdata_in;
  assign bus.wr    = wr_in;
  assign bus.rd    = rd_in;

  function automatic logic hit(input logic [7:0] a);
    hit = (a == ccss_pkg::CLOCK_SPEED_CONTROL_ADDR);
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic       edge_div;
    logic       tick;
    logic       half_mid;
    logic       mode;
    logic [3:0] ph;
    edge_div   = 1'b0;
    tick       = 1'b0;
    half_mid   = 1'b0;
    mode       = 1'b0;
    ph         = 4'h0;
    state_next = state_reg;
    // Divided clock rises when toggle goes 0 to 1
    edge_div   = ~state_reg.half_tgl;
    state_next.half_tgl = ~state_reg.half_tgl;
    if (bus.wr && hit(bus.addr)) begin
      // Bit 7 dropped: reserved, never stored
      state_next.ctrl[6:1] = bus.wdata[6:1];
      state_next.ctrl[0]   = bus.wdata[0];
    end
    // Mode latched only at divided-clock edge, avoids short cycles
    mode = state_reg.double_active;
    if (edge_div && state_reg.phase == 4'h0) begin
      mode = state_reg.ctrl[ccss_pkg::BIT_DOUBLE_SPEED_MODE];
    end
    state_next.double_active = mode;
    // Phase counts oscillator clocks, wraps at 12
    ph = (state_reg.phase == ccss_pkg::PHASE_LAST) ? 4'h0
         : state_reg.phase + 4'h1;
    state_next.phase = ph;
    tick     = (state_reg.phase == 4'h0);
    half_mid = (state_reg.phase == ccss_pkg::DOUBLE_PERIODS);
    // CPU: 12 clocks standard, 6 in double speed
    state_next.cpu_en = tick || (state_reg.double_active && half_mid);
    for (int i = 0; i < ccss_pkg::NUM_PERIPH; i++) begin
      // Doubled only in double mode with own bit clear
      if (state_reg.double_active &&
          !state_reg.ctrl[i + 1]) begin
        state_next.periph_en[i] = tick || half_mid;
      end else begin
        state_next.periph_en[i] = tick;
      end
    end
    state_next.rdata = ccss_pkg::UNMAPPED_READ;
    if (bus.rd && hit(bus.addr)) begin
      state_next.rdata = {1'b0, state_reg.ctrl};
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!reset_n_in) begin
      state_reg     <= '0;
      boot_seen_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      boot_seen_reg <= 1'b1;
      // Boot option sampled once at first edge after release
      if (!boot_seen_reg && boot_double_speed_in) begin
        state_reg.ctrl[ccss_pkg::BIT_DOUBLE_SPEED_MODE] <= 1'b1;
        state_reg.double_active                         <= 1'b1;
      end
    end
  end

  assign rdata_out           = state_reg.rdata;
  assign cpu_cycle_en_out    = state_reg.cpu_en;
  assign periph_cycle_en_out = state_reg.periph_en;
  assign double_active_out   = state_reg.double_active;
endmodule

// File: ccss_pkg.sv
package ccss_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CLOCK_SPEED_CONTROL_ADDR = 8'h8F;
  localparam logic [7:0] CLOCK_SPEED_CONTROL_RST  = 8'h00;
  localparam int         BIT_DOUBLE_SPEED_MODE    = 0;
  localparam int         BIT_TIMER_ZERO           = 1;
  localparam int         BIT_TIMER_ONE            = 2;
  localparam int         BIT_TIMER_TWO            = 3;
  localparam int         BIT_SERIAL               = 4;
  localparam int         BIT_COUNTER_ARRAY        = 5;
  localparam int         BIT_WDOG                 = 6;
  localparam int         NUM_PERIPH               = 6;
  localparam logic [7:0] UNMAPPED_READ            = 8'h00;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam logic [3:0] STD_PERIODS    = 4'hC;
  localparam logic [3:0] DOUBLE_PERIODS = 4'h6;
  localparam logic [3:0] PHASE_LAST     = 4'hB;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ccss_bus_s;

  typedef struct packed {
    logic [6:0] ctrl;
    logic       half_tgl;
    logic [3:0] phase;
    logic       cpu_en;
    logic [5:0] periph_en;
    logic [7:0] rdata;
    logic       double_active;
  } ccss_state_s;
endpackage

// File: ccss_properties.sv
`timescale 1ns/1ps
module ccss_chk (input wire logic core_clk_in, reset_n_in,
  boot_double_speed_in, rd_in, cpu_cycle_en_out, double_active_out,
  input wire logic [7:0] addr_in, rdata_out,
  input wire logic [5:0] periph_cycle_en_out);
  logic c, d, b;
  assign c = cpu_cycle_en_out;
  assign d = double_active_out;
  assign b = boot_double_speed_in;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  AST_MIN: assert property (c |=> !c[*5]) else $error("gap short");
  AST_MAX: assert property (c |-> ##[1:12] c) else $error("gap long");
  AST_STD: assert property (c && !d ##1 !d |-> !c[*8])
    else $error("std gap");
  AST_BOOT: assert property ($rose(reset_n_in) && b |-> ##[1:14] d)
    else $error("boot");
  AST_RST: assert property ($rose(reset_n_in) && !b |-> !d[*8])
    else $error("reset");
  AST_UNM: assert property (rd_in && addr_in != 8'h8f |=> !rdata_out)
    else $error("unmapped");
  AST_B7: assert property (rd_in |=> !rdata_out[7]) else $error("b7");
  AST_PER: assert property (!d[*3] |->
    periph_cycle_en_out inside {0, 63}) else $error("std periph");
endmodule
bind ccss_core ccss_chk chk (.core_clk_in, .reset_n_in, .boot_double_speed_in,
  .rd_in, .cpu_cycle_en_out, .double_active_out, .addr_in, .rdata_out,
  .periph_cycle_en_out);

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic core_clk_in = 0, reset_n_in = 0, boot_double_speed_in = 0, wr_in = 0;
  logic rd_in = 0, cpu_cycle_en_out, double_active_out;
  logic [7:0] addr_in = 0, wdata_in = 0, rdata_out;
  logic [5:0] periph_cycle_en_out;
  wire [6:0] ev = {cpu_cycle_en_out, periph_cycle_en_out};
  int miscompares = 0, n_tests = 0, cyc = 0, seed = 32'h8f42f5ab, ctl, c;
  ccss_core dut (.core_clk_in, .reset_n_in, .boot_double_speed_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .cpu_cycle_en_out,
    .periph_cycle_en_out, .double_active_out);
  initial forever #50 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) if (++cyc == 9000) wrap_up(1);
  task chk(input logic [7:0] got, input int exp);
    n_tests++;
    miscompares += (got !== exp[7:0]);
    if (got !== exp[7:0]) $display("BAD %0t %h %h", $time, got, exp[7:0]);
  endtask
  task bus(input logic w, input logic [7:0] a, dt);
    @(posedge core_clk_in);
    {addr_in, wdata_in, wr_in, rd_in} <= {a, dt, w, !w};
    @(posedge core_clk_in);
    {wr_in, rd_in} <= 2'h0;
    #1;
  endtask
  // Interval between two strobes, not phase, so no alignment is assumed
  task gap(input int k);
    c = 0;
    @(posedge core_clk_in iff ev[k] === 1'b1);
    do @(posedge core_clk_in) c++; while (ev[k] !== 1'b1);
    chk(c, k > 5 ? (ctl[0] ? 6 : 12) : ctl[0] && !ctl[k+1] ? 6 : 12);
  endtask
  initial begin
    for (int b = 0; b < 2; b++) begin
      {reset_n_in, boot_double_speed_in} <= {1'b0, b[0]};
      repeat (10) @(posedge core_clk_in);
      reset_n_in <= 1;
      ctl = b;
      for (int n = 0; n < 6; n++) begin
        bus(0, 8'h8f, 0);
        chk(rdata_out, ctl);
        bus(0, 8'h8e, 0);
        chk(rdata_out, 0);
        repeat (30) @(posedge core_clk_in);
        chk(double_active_out, ctl[0]);
        for (int k = 0; k < 7; k++) gap(k);
        $display("test %0d.%0d done", b, n);
        ctl = $random(seed) & 127;
        bus(1, 8'h8f, ctl[7:0]);
      end
    end
    wrap_up(0);
  end
  task wrap_up(input int h);
    miscompares += h;
    $display("tests %0d bad %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
endmodule
